/* File: design/dbg_pin_cfg.svh */
// Purpose: constants for the debug port pin assignment block
// Assumes: included by bare name from design files
// Notes: pin index order is mode_select, clock, data_in, data_out, test_reset
`ifndef DBG_PIN_CFG_SVH
`define DBG_PIN_CFG_SVH
`define PIN_COUNT 5
`define PIN_TMS 0
`define PIN_TCK 1
`define PIN_TDI 2
`define PIN_TDO 3
`define PIN_TRST 4
// ownership setting encodings
`define OWN_FULL 2'h0
`define OWN_NO_TRST 2'h1
`define OWN_SWD_ONLY 2'h2
`define OWN_NONE 2'h3
`define OWN_RESET `OWN_FULL
// owned-pin masks per setting
`define MASK_FULL 5'h1F
`define MASK_NO_TRST 5'h0F
`define MASK_SWD_ONLY 5'h03
`define MASK_NONE 5'h00
// pin functions after reset: every pin on the debug port
`define FN_RESET 10'h155
// pull codes when owned by the debug port: up on tms, tdi, trst; down on tck; none on tdo
`define PULL_UP_MASK 5'h15
`define PULL_DN_MASK 5'h02
`endif

/* File: design/dbg_pin_pkg.sv */
// Purpose: types for the debug port pin assignment block
// Assumes: nothing
// Notes: pin function codes driven toward the pad ring
package dbg_pin_pkg;
    typedef enum logic [1:0] {
        FN_GPIO_IN = 2'h0,
        FN_DEBUG = 2'h1,
        FN_ALT = 2'h2,
        FN_TRACE = 2'h3
    } pin_fn_t;
endpackage

/* File: design/dbg_sync2.sv */
// Purpose: two flip-flop synchroniser for a vector of pad inputs
// Assumes: single clock domain on clk_i
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module dbg_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta_r;
        logic [WIDTH-1:0] q_r;
    } sync_state_t;
    sync_state_t state_r;
    sync_state_t state_nxt;
    // an empty vector has nothing to synchronise
    if (WIDTH < 1) begin : g_width_check
        $error("dbg_sync2: WIDTH must be at least 1");
    end
    // shift through two stages
    always_comb begin
        state_nxt = state_r;
        state_nxt.meta_r = d_i;
        state_nxt.q_r = state_r.meta_r;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign q_o = state_r.q_r;
endmodule

/* File: design/debug_port_pin_assignment.sv */
// Purpose: pin ownership mux for a combined two-wire/scan debug port on five pins
// Assumes: core_clk_i at 125 MHz; probe clock is sampled as an ordinary input
// Notes: pin index 0 mode_select/data, 1 clock, 2 data_in, 3 data_out/trace, 4 test_reset
`timescale 1ns/1ps
`include "dbg_pin_cfg.svh"
module debug_port_pin_assignment
    import dbg_pin_pkg::*;
#(
    parameter int PINS = `PIN_COUNT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic own_wr_i,
    input wire logic [1:0] own_sel_i,
    input wire logic trace_en_i,
    input wire logic trace_data_i,
    input wire logic [PINS-1:0] pad_in_i,
    input wire logic swdio_out_i,
    input wire logic swdio_oe_i,
    input wire logic tdo_data_i,
    input wire logic swd_mode_i,
    output logic [1:0] own_sel_o,
    output logic [PINS-1:0] debug_own_o,
    output logic [PINS-1:0] pull_up_o,
    output logic [PINS-1:0] pull_dn_o,
    output logic [PINS-1:0] pad_out_o,
    output logic [PINS-1:0] pad_oe_o,
    output logic [PINS-1:0] gpio_in_o,
    output logic [9:0] pin_fn_o,
    output logic dbg_tms_swdio_o,
    output logic dbg_tck_o,
    output logic dbg_tck_rise_o,
    output logic dbg_tdi_o,
    output logic dbg_trst_n_o
);
    typedef struct packed {
        logic [1:0] own_r;
        logic [1:0] pend_r;
        logic pend_v_r;
        logic [PINS-1:0] mask_r;
        logic [PINS-1:0] up_r;
        logic [PINS-1:0] dn_r;
        logic [PINS-1:0] out_r;
        logic [PINS-1:0] oe_r;
        logic [PINS-1:0] gin_r;
        logic [9:0] fn_r;
        logic tms_r;
        logic tck_r;
        logic tck_rise_r;
        logic tdi_r;
        logic trst_n_r;
    } dbg_state_t;
    dbg_state_t state_r;
    dbg_state_t state_nxt;
    logic [PINS-1:0] pad_s;
    // pull pattern per pin, indexed so each pin takes exactly its own bit
    localparam logic [PINS-1:0] UP_PULLS = `PULL_UP_MASK;
    localparam logic [PINS-1:0] DN_PULLS = `PULL_DN_MASK;
    // the pin map and masks below are fixed to five pads
    if (PINS != `PIN_COUNT) begin : g_pins_check
        $error("debug_port_pin_assignment: PINS must be 5");
    end
    // pad inputs pass two flops before use, probe clock included
    dbg_sync2 #(.WIDTH(PINS)) u_sync (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(pad_in_i),
        .q_o(pad_s)
    );
    function automatic logic [PINS-1:0] mask_of(input logic [1:0] sel);
        logic [PINS-1:0] m;
        m = `MASK_NONE;
        unique case (sel)
            `OWN_FULL: m = `MASK_FULL;
            `OWN_NO_TRST: m = `MASK_NO_TRST;
            `OWN_SWD_ONLY: m = `MASK_SWD_ONLY;
            `OWN_NONE: m = `MASK_NONE;
        endcase
        return m;
    endfunction
    // ownership update, pin functions, pulls and debug-side inputs
    always_comb begin
        state_nxt = state_r;
        // probe clock reaches the core only through an owned pin
        // released clock pin parks at its pull-down level, so no false edge
        state_nxt.tck_r = state_r.mask_r[`PIN_TCK] & pad_s[`PIN_TCK];
        state_nxt.tck_rise_r = state_nxt.tck_r & ~state_r.tck_r;
        // capture the write, apply only while the probe clock is low
        // a change while the clock is high could cut a clock pulse short
        if (own_wr_i) begin
            state_nxt.pend_r = own_sel_i;
            state_nxt.pend_v_r = 1'b1;
        end
        if (state_r.pend_v_r && !pad_s[`PIN_TCK] && !own_wr_i) begin
            state_nxt.own_r = state_r.pend_r;
            state_nxt.pend_v_r = 1'b0;
        end
        state_nxt.mask_r = mask_of(state_r.own_r);
        state_nxt.out_r = '0;
        state_nxt.oe_r = '0;
        state_nxt.fn_r = '0;
        // per pin: owned, released two-wire pin, or released scan pin
        for (int i = 0; i < PINS; i++) begin
            if (state_r.mask_r[i]) begin
                state_nxt.fn_r[2*i +: 2] = FN_DEBUG;
                state_nxt.up_r[i] = UP_PULLS[i];
                state_nxt.dn_r[i] = DN_PULLS[i];
            end else if (i <= `PIN_TCK) begin
                state_nxt.fn_r[2*i +: 2] = FN_ALT;
                state_nxt.up_r[i] = UP_PULLS[i];
                state_nxt.dn_r[i] = DN_PULLS[i];
            end else begin
                state_nxt.fn_r[2*i +: 2] = FN_GPIO_IN;
                state_nxt.up_r[i] = UP_PULLS[i];
                state_nxt.dn_r[i] = 1'b0; // data-out floats
            end
        end
        // two-wire data is bidirectional on mode select pin
        if (state_r.mask_r[`PIN_TMS] && swd_mode_i) begin
            state_nxt.out_r[`PIN_TMS] = swdio_out_i;
            state_nxt.oe_r[`PIN_TMS] = swdio_oe_i;
        end
        // data-out: scan output, or trace in two-wire mode
        if (state_r.mask_r[`PIN_TDO]) begin
            if (!swd_mode_i) begin
                state_nxt.out_r[`PIN_TDO] = tdo_data_i;
                state_nxt.oe_r[`PIN_TDO] = 1'b1;
            end else if (trace_en_i) begin
                state_nxt.out_r[`PIN_TDO] = trace_data_i;
                state_nxt.oe_r[`PIN_TDO] = 1'b1;
                state_nxt.fn_r[2*`PIN_TDO +: 2] = FN_TRACE;
            end
        end
        // debug-side inputs; released pins park at pull levels
        state_nxt.tms_r = state_r.mask_r[`PIN_TMS] ? pad_s[`PIN_TMS] : 1'b1;
        state_nxt.tdi_r = (state_r.mask_r[`PIN_TDI] && !swd_mode_i) ? pad_s[`PIN_TDI] : 1'b1;
        state_nxt.trst_n_r = (state_r.mask_r[`PIN_TRST] && !swd_mode_i) ? pad_s[`PIN_TRST] : 1'b1;
        // released pins are seen by the gpio side only
        state_nxt.gin_r = pad_s & ~state_r.mask_r;
    end
    // state register; reset owns all pins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= '0;
            state_r.own_r <= `OWN_RESET;
            state_r.mask_r <= `MASK_FULL;
            state_r.up_r <= `PULL_UP_MASK;
            state_r.dn_r <= `PULL_DN_MASK;
            state_r.fn_r <= `FN_RESET;
            state_r.tms_r <= 1'b1;
            state_r.tdi_r <= 1'b1;
            state_r.trst_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end
    // every output is a field of the state register
    assign own_sel_o = state_r.own_r;
    assign debug_own_o = state_r.mask_r;
    assign pull_up_o = state_r.up_r;
    assign pull_dn_o = state_r.dn_r;
    assign pad_out_o = state_r.out_r;
    assign pad_oe_o = state_r.oe_r;
    assign gpio_in_o = state_r.gin_r;
    assign pin_fn_o = state_r.fn_r;
    assign dbg_tms_swdio_o = state_r.tms_r;
    assign dbg_tck_o = state_r.tck_r;
    assign dbg_tck_rise_o = state_r.tck_rise_r;
    assign dbg_tdi_o = state_r.tdi_r;
    assign dbg_trst_n_o = state_r.trst_n_r;

    a_reset_full: assert property (@(posedge core_clk_i) rst_i |=> debug_own_o == `MASK_FULL)
        else $error("reset did not own all pins");
    a_trace_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pin_fn_o[7:6] == FN_TRACE |-> $past(trace_en_i) && $past(swd_mode_i))
        else $error("trace assigned without enable");
    a_own_apply: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(own_sel_o) |-> !$past(pad_s[`PIN_TCK]))
        else $error("ownership changed while clock high");
    a_mask_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(own_sel_o) |=> debug_own_o == mask_of($past(own_sel_o)))
        else $error("mask does not follow setting");
    a_released_oe: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##1 (pad_oe_o & ~$past(debug_own_o)) == '0)
        else $error("released pin driven by debug");
    a_owned_pulls: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $stable(debug_own_o) && debug_own_o[`PIN_TCK] |=> pull_dn_o[`PIN_TCK] && !pull_up_o[`PIN_TCK])
        else $error("clock pin pull wrong");
    a_tdo_float: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !debug_own_o[`PIN_TDO] |=> !pull_up_o[`PIN_TDO] && !pull_dn_o[`PIN_TDO])
        else $error("released data-out not floating");
    a_swd_alt: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !debug_own_o[`PIN_TMS] |=> pin_fn_o[1:0] == FN_ALT && pull_up_o[`PIN_TMS])
        else $error("released data line not alternate pull-up");
    a_trst_scan: assert property (@(posedge core_clk_i) disable iff (rst_i)
        swd_mode_i |=> dbg_trst_n_o)
        else $error("test reset active in two-wire mode");
    // data-in has no two-wire role, so the core sees its idle level
    a_tdi_scan: assert property (@(posedge core_clk_i) disable iff (rst_i)
        swd_mode_i |=> dbg_tdi_o)
        else $error("data-in live in two-wire mode");
    // a released clock pin must not clock the debug core
    a_tck_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !debug_own_o[`PIN_TCK] |=> !dbg_tck_o && !dbg_tck_rise_o)
        else $error("released clock still reaches core");
    // owned data-out in scan mode always drives the scan output
    a_tdo_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
        debug_own_o[`PIN_TDO] && !swd_mode_i |=> pad_oe_o[`PIN_TDO])
        else $error("scan data-out not driven");
    // the clock pin is an input only, never driven
    a_tck_input: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !pad_oe_o[`PIN_TCK])
        else $error("clock pin driven");
    // main scenarios: full release, two-wire only, trace, partial release
    c_release_all: cover property (@(posedge core_clk_i) own_sel_o == `OWN_NONE);
    c_no_trst: cover property (@(posedge core_clk_i) own_sel_o == `OWN_NO_TRST);
    c_swd_only: cover property (@(posedge core_clk_i) own_sel_o == `OWN_SWD_ONLY);
    c_trace: cover property (@(posedge core_clk_i) pin_fn_o[7:6] == FN_TRACE);
endmodule

/* File: tb/debug_probe_model.sv */
// Purpose: behavioural debug probe that drives four of the five debug pads, all but data-out
// Assumes: the bench resolves the shared data line from both drive enables
// Notes: link clock period 64 ns, runs only inside frames, parks low or high outside
`timescale 1ns/1ps
module debug_probe_model (
    input wire logic run_i,
    input wire logic park_high_i,
    output logic tck_o,
    output logic swdio_d_o,
    output logic swdio_oe_o,
    output logic tdi_o,
    output logic trst_n_o
);
    logic [7:0] pat = 8'hA5;
    // data moves while the clock is low, one bit per link clock period
    initial begin
        tck_o = 1'b0;
        swdio_d_o = 1'b0;
        swdio_oe_o = 1'b0;
        tdi_o = 1'b1;
        trst_n_o = 1'b1; // scan logic kept out of its own reset
        #3;
        forever begin
            if (run_i) begin
                swdio_oe_o = 1'b1; // data shares the mode select pad
                swdio_d_o = pat[0];
                tdi_o = pat[1];
                #32 tck_o = 1'b1; // clock is an input to the device only
                #32 tck_o = 1'b0;
                pat = {pat[6:0], pat[7] ^ pat[5]};
            end else begin
                swdio_oe_o = 1'b0; // line released, pull-up takes it
                tdi_o = 1'b1;
                tck_o = park_high_i;
                #8;
            end
        end
    end
endmodule

/* File: tb/debug_port_pin_assignment_tb.sv */
// Purpose: self-checking bench for the debug pin ownership mux
// Assumes: probe model on the pads, pads resolved with pulls in this module
// Notes: driver queues expected settings, monitor pops one per pin function change
`timescale 1ns/1ps
`include "dbg_pin_cfg.svh"
module debug_port_pin_assignment_tb import dbg_pin_pkg::*;;
    typedef struct packed {logic tr; logic [1:0] sel;} note_t;
    note_t notes[$];
    note_t n;
    logic core_clk_i = 1'b0, rst_i, own_wr_i, trace_en_i, swdio_oe_i, swd_mode_i, run, park;
    logic [1:0] own_sel_i, cur;
    logic trace_data_i = 1'b0, swdio_out_i = 1'b0, tdo_data_i = 1'b0, trace_prev = 1'b0;
    logic [31:0] seed = 32'h7D2C;
    logic [9:0] fn_prev;
    logic [1:0] own_sel_o;
    logic [4:0] debug_own_o, pull_up_o, pull_dn_o, pad_out_o, pad_oe_o, gpio_in_o;
    logic [9:0] pin_fn_o;
    logic tms_o, tck_o, rise_o, tdi_o, trst_n_o, p_tck, p_d, p_oe, p_tdi, p_trst_n;
    int err_count = 0, checks_done = 0, rise_seen = 0, rise_sent = 0;
    // pads: owned data line pulled up, floating data-out toggles with the random stream
    wire [4:0] pad = {p_trst_n, pad_oe_o[3] ? pad_out_o[3] : seed[9], p_tdi, p_tck,
                      pad_oe_o[0] ? pad_out_o[0] : (p_oe ? p_d : 1'b1)};
    initial forever #4 core_clk_i = ~core_clk_i;
    debug_probe_model debug_probe_model_i (.run_i(run), .park_high_i(park), .tck_o(p_tck), .swdio_d_o(p_d),
        .swdio_oe_o(p_oe), .tdi_o(p_tdi), .trst_n_o(p_trst_n));
    debug_port_pin_assignment debug_port_pin_assignment_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .own_wr_i(own_wr_i), .own_sel_i(own_sel_i), .trace_en_i(trace_en_i), .trace_data_i(trace_data_i),
        .pad_in_i(pad), .swdio_out_i(swdio_out_i), .swdio_oe_i(swdio_oe_i), .tdo_data_i(tdo_data_i),
        .swd_mode_i(swd_mode_i), .own_sel_o(own_sel_o), .debug_own_o(debug_own_o), .pull_up_o(pull_up_o),
        .pull_dn_o(pull_dn_o), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .gpio_in_o(gpio_in_o),
        .pin_fn_o(pin_fn_o), .dbg_tms_swdio_o(tms_o), .dbg_tck_o(tck_o), .dbg_tck_rise_o(rise_o),
        .dbg_tdi_o(tdi_o), .dbg_trst_n_o(trst_n_o));
    // xorshift step for the random stream
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [4:0] mask_of(input logic [1:0] s);
        return s == `OWN_FULL ? `MASK_FULL : s == `OWN_NO_TRST ? `MASK_NO_TRST :
               s == `OWN_SWD_ONLY ? `MASK_SWD_ONLY : `MASK_NONE;
    endfunction
    // released two-wire pads go alternate, released scan pads go gpio input
    function automatic logic [9:0] fn_of(input note_t t);
        logic [4:0] m;
        m = mask_of(t.sel);
        fn_of = '0;
        for (int p = 0; p < `PIN_COUNT; p++) fn_of[2*p+:2] = m[p] ? FN_DEBUG : (p < 2 ? FN_ALT : FN_GPIO_IN);
        if (t.tr && m[`PIN_TDO]) fn_of[2*`PIN_TDO+:2] = FN_TRACE;
    endfunction
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_empty;
        for (int i = 0; i < 40 && notes.size() != 0; i++) @(posedge core_clk_i);
        if (notes.size() != 0) begin
            err_count++;
            $display("FAIL setting not applied in time");
            results();
        end
    endtask
    task automatic wr_own(input logic [1:0] s);
        notes.push_back(note_t'({1'b0, s}));
        own_wr_i <= 1'b1;
        own_sel_i <= s;
        @(posedge core_clk_i);
        own_wr_i <= 1'b0;
        cur = s;
    endtask
    task automatic set_own(input logic [1:0] s);
        wr_own(s);
        wait_empty();
    endtask
    task automatic chk_reset;
        #1;
        chk("reset own", 10'(debug_own_o), 10'(`MASK_FULL));
        chk("reset fn", pin_fn_o, `FN_RESET);
        chk("reset sel", 10'(own_sel_o), 10'(`OWN_RESET));
    endtask
    task automatic frame(input logic owned);
        int r0;
        int e0;
        r0 = rise_seen;
        e0 = rise_sent;
        run <= 1'b1;
        repeat (80) @(posedge core_clk_i);
        run <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        chk("clock rises", 10'(rise_seen - r0), owned ? 10'(rise_sent - e0) : 10'h000);
    endtask
    // random stream feeds the core-side data inputs every cycle
    always @(posedge core_clk_i) begin
        seed <= xs(seed);
        trace_data_i <= seed[2];
        trace_prev <= trace_data_i;
        swdio_out_i <= seed[1];
        tdo_data_i <= seed[0];
        if (rise_o === 1'b1) rise_seen <= rise_seen + 1;
    end
    always @(posedge p_tck) rise_sent <= rise_sent + 1;
    // monitor: each pin function change consumes the oldest expected setting
    always @(posedge core_clk_i) begin
        if (rst_i === 1'b0 && pin_fn_o !== fn_prev) begin
            if (notes.size() == 0) begin
                chk("unexpected change", 10'h001, 10'h000);
            end else begin
                n = notes.pop_front();
                chk("own", 10'(debug_own_o), 10'(mask_of(n.sel)));
                chk("fn", pin_fn_o, fn_of(n));
                chk("sel", 10'(own_sel_o), 10'(n.sel));
                chk("pull up", 10'(pull_up_o), 10'(`PULL_UP_MASK));
                chk("pull dn", 10'(pull_dn_o), 10'(`PULL_DN_MASK));
            end
        end
        fn_prev <= pin_fn_o;
    end
    initial begin
        rst_i <= 1'b1;
        {own_wr_i, own_sel_i, trace_en_i, swd_mode_i, swdio_oe_i, run, park} <= '0;
        cur = `OWN_RESET;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        chk_reset();
        @(posedge core_clk_i);
        for (int k = 1; k < 5; k++) set_own(2'(k));
        for (int k = 0; k < 8; k++) begin
            if (seed[5:4] !== cur) set_own(seed[5:4]);
            @(posedge core_clk_i);
        end
        if (cur !== `OWN_FULL) set_own(`OWN_FULL);
        // a setting must not land while the probe clock is high
        park <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        wr_own(`OWN_NONE);
        repeat (12) @(posedge core_clk_i);
        chk("held sel", 10'(own_sel_o), 10'(`OWN_FULL));
        park <= 1'b0;
        wait_empty();
        set_own(`OWN_FULL);
        // bench enables async trace in two-wire mode
        notes.push_back(note_t'({1'b1, `OWN_FULL}));
        {swd_mode_i, swdio_oe_i, trace_en_i} <= 3'h7;
        wait_empty();
        repeat (4) @(posedge core_clk_i);
        chk("trace drive", 10'({pad_oe_o[3], pad_oe_o[0]}), 10'h003);
        chk("trace data", 10'(pad_out_o[3]), 10'(trace_prev));
        notes.push_back(note_t'({1'b0, `OWN_FULL}));
        {swd_mode_i, swdio_oe_i, trace_en_i} <= 3'h0;
        wait_empty();
        frame(1'b1);
        set_own(`OWN_NONE);
        frame(1'b0);
        chk("gpio levels", 10'(gpio_in_o & 5'h17), 10'h015);
        chk("core levels", 10'({tms_o, tdi_o, trst_n_o, tck_o}), 10'h00E);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        chk_reset();
        results();
    end
endmodule
